//--- logic/odbc_regs.vh
/*
 Constants for the host-side controller of an eight-channel double-buffered
 converter: register offsets, field positions, reset values, pin timing.
 Assumes a 10 MHz clock and a 32-bit Avalon-MM slave port.
*/
// Function
// - Host drives each channel code on a 13-bit parallel code bus.
// - All four loads together update all eight converter latches at once.
// - Host holds channel select stable while select and write are low.
// - Load low during a write stays low a load pulse time after.
// - Codes are offset binary; two's complement converts by adding 4096.
`ifndef ODBC_REGS_VH
`define ODBC_REGS_VH
// Register byte offsets
`define ODBC_REG_CTRL 4'h0
`define ODBC_REG_CODE 4'h4
`define ODBC_REG_STATUS 4'h8
`define ODBC_REG_LOAD 4'hc
// CTRL fields
`define ODBC_CTRL_WRITE 0
`define ODBC_CTRL_LOAD 1
`define ODBC_CTRL_CLEAR 2
`define ODBC_CTRL_TWOS 3
`define ODBC_CTRL_LDWR 4
// CODE fields
`define ODBC_CODE_LSB 0
`define ODBC_CODE_MSB 12
`define ODBC_CHAN_LSB 16
`define ODBC_CHAN_MSB 18
// STATUS fields
`define ODBC_STAT_BUSY 0
// Reset and code values
`define ODBC_MID_CODE 13'h1000
`define ODBC_TWOS_OFFSET 13'h1000
`define ODBC_LOAD_RESET 4'hf
// Timing, ns and clock
`define ODBC_CLK_NS 100
`define ODBC_T_WR_NS 50
`define ODBC_T_SETUP_NS 50
`define ODBC_T_LD_NS 50
`define ODBC_T_CLR_NS 100
`define ODBC_CYC(ns) (((ns) + `ODBC_CLK_NS - 1) / `ODBC_CLK_NS)
`endif

//--- logic/odbc_host.v
/*
 Host controller for an eight-channel double-buffered converter. Software
 orders writes, loads and clears through Avalon-MM registers; the block
 drives the converter's chip select, write strobe, select lines, code bus,
 pair loads and clear. Assumes the converter keeps its own latch behaviour.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odbc_regs.vh"
module odbc_host #(
    parameter CODE_W = 13,
    parameter N_PAIR = 4
) (
    input wire clk, // 10 MHz clock
    input wire rst_b, // Async reset, active low
    input wire [3:0] avs_address, // Byte address
    input wire avs_read, // Read request
    input wire avs_write, // Write request
    input wire [31:0] avs_writedata, // Write data
    input wire [3:0] avs_byteenable, // Byte lanes
    output reg [31:0] avs_readdata, // Read data
    output reg avs_waitrequest, // Stall
    output reg chip_select_n, // Converter chip select
    output reg write_strobe_n, // Converter write strobe
    output reg channel_select_bit0, // Channel index bit 0
    output reg channel_select_bit1, // Channel index bit 1
    output reg channel_select_bit2, // Channel index bit 2
    output reg [CODE_W-1:0] code_bus, // Parallel code
    output reg load_pair_first_n, // Pair load, channels 1-2
    output reg load_pair_second_n, // Pair load, channels 3-4
    output reg load_pair_third_n, // Pair load, channels 5-6
    output reg load_pair_fourth_n, // Pair load, channels 7-8
    output reg clear_all_n // Clear, active low
);
    // Sequencing overview
    // The converter has no clock of its own: every control pin acts on its
    // level. This block turns each software order into a short, fixed run
    // of pin levels, one clock period per step, so that every minimum pulse
    // width and setup time is met at 10 MHz; the clear pulse exactly, the rest with margin.
    //
    // Write order, cycle 0 being the edge that takes the CTRL write:
    //   cycle 1  chip select low, select lines and code bus driven
    //   cycle 2  write strobe low; the addressed input latch is open
    //   cycle 3  write strobe and chip select high together; the latch
    //            closes on whatever the code bus shows at that moment
    // The select lines and the code bus are not touched again until the
    // next write order, so they stay valid through the whole strobe and
    // beyond it, which covers the hold times at zero cost.
    //
    // Write with pair load, same cycle numbering:
    //   cycle 2  internal load vector low for the addressed pair
    //   cycle 3  pair load pin low (the pin stage adds one register)
    //   cycle 4  internal vector high again
    //   cycle 5  pair load pin high
    // The load pin therefore stays low well after the strobe has risen,
    // so the converter latch captures the settled input latch contents.
    //
    // Load order:
    //   cycle 1  internal vector low for every pair in the mask
    //   cycle 2  pair load pins low, cycle 3 pins high
    //
    // Clear order:
    //   cycle 1  clear low for one period, high again at cycle 2
    //   the stored code returns to mid-scale as the latches do
    //
    // Hazard: the pair load pins trail the internal vector by one cycle.
    // Software must read STATUS busy low and allow one more cycle before
    // relying on the converter outputs; a status poll always takes longer.
    //
    // Timing counts in whole clock periods, rounded up from nanoseconds
    localparam integer CYC_SETUP = `ODBC_CYC(`ODBC_T_SETUP_NS);
    localparam integer CYC_WR = `ODBC_CYC(`ODBC_T_WR_NS);
    localparam integer CYC_LD = `ODBC_CYC(`ODBC_T_LD_NS);
    localparam integer CYC_CLR = `ODBC_CYC(`ODBC_T_CLR_NS);
    // Counts cut to the width of the step counter
    localparam [3:0] C_SETUP = CYC_SETUP[3:0];
    localparam [3:0] C_WR = CYC_WR[3:0];
    localparam [3:0] C_LD = CYC_LD[3:0];
    localparam [3:0] C_CLR = CYC_CLR[3:0];
    // Sequencer states
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_SETUP = 3'h1;
    localparam [2:0] S_STROBE = 3'h2;
    localparam [2:0] S_LDHOLD = 3'h3;
    localparam [2:0] S_LOAD = 3'h4;
    localparam [2:0] S_CLEAR = 3'h5;

    reg [2:0] state;
    reg [3:0] count;
    reg [CODE_W-1:0] code_reg;
    reg [2:0] chan_reg;
    reg twos_mode;
    reg [N_PAIR-1:0] load_mask;
    reg [N_PAIR-1:0] load_out_n;
    reg ld_with_wr;
    reg [CODE_W-1:0] next_code;
    reg [N_PAIR-1:0] pair_of_chan;
    wire busy;
    wire bus_wr;
    wire bus_rd;
    wire twos_now;
    genvar gi;

    // Busy covers every sequencer state of every order
    assign busy = (state != S_IDLE);
    // Accesses complete at the edge where waitrequest is low
    assign bus_wr = avs_write & ~avs_waitrequest;
    assign bus_rd = avs_read & ~avs_waitrequest;
    // Mode as it stands for this write: a CTRL write that sets the mode
    // and starts a write in one word must convert with the new mode,
    // because the code bus is loaded at the same edge as the mode bit
    assign twos_now = (bus_wr && (avs_address == `ODBC_REG_CTRL)) ?
        avs_writedata[`ODBC_CTRL_TWOS] : twos_mode;

    // Offset binary conversion when the stored code is two's complement
    // The sum wraps at 13 bits, which is the intended conversion
    always @* begin
        if (twos_now)
            next_code = code_reg + `ODBC_TWOS_OFFSET;
        else
            next_code = code_reg;
    end

    // Pair mask for the addressed channel, index divided by two
    generate
        for (gi = 0; gi < N_PAIR; gi = gi + 1) begin : g_pair
            always @* begin
                pair_of_chan[gi] = (chan_reg[2:1] == gi);
            end
        end
    endgenerate

    // Avalon slave: one wait cycle per access, then the answer
    // Waitrequest rests high; a request seen while it is high drops it
    // for exactly one cycle, and read data are registered at that edge
    // so they stand while waitrequest is low. Reads never stall longer,
    // even while the sequencer is busy: status must stay readable.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            if ((avs_read | avs_write) & avs_waitrequest)
                avs_waitrequest <= 1'b0;
            else
                avs_waitrequest <= 1'b1;
            if (avs_read & avs_waitrequest) begin
                case (avs_address)
                    `ODBC_REG_CTRL: avs_readdata <=
                        {28'h0, twos_mode, 3'h0};
                    `ODBC_REG_CODE: avs_readdata <=
                        {13'h0, chan_reg, 3'h0, code_reg};
                    `ODBC_REG_STATUS: avs_readdata <= {31'h0, busy};
                    `ODBC_REG_LOAD: avs_readdata <=
                        {{(32-N_PAIR){1'b0}}, load_mask};
                    default: avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // Registers, sequencer and pin drive
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            count <= 4'h0;
            code_reg <= `ODBC_MID_CODE;
            chan_reg <= 3'h0;
            twos_mode <= 1'b0;
            load_mask <= `ODBC_LOAD_RESET;
            load_out_n <= {N_PAIR{1'b1}};
            ld_with_wr <= 1'b0;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            channel_select_bit0 <= 1'b0;
            channel_select_bit1 <= 1'b0;
            channel_select_bit2 <= 1'b0;
            code_bus <= `ODBC_MID_CODE;
            clear_all_n <= 1'b1;
            load_pair_first_n <= 1'b1;
            load_pair_second_n <= 1'b1;
            load_pair_third_n <= 1'b1;
            load_pair_fourth_n <= 1'b1;
        end else begin
            // Register writes take effect only while idle
            // A write during a running order is acknowledged and dropped,
            // so software cannot move the code or select lines mid-strobe
            if (bus_wr && !busy && avs_byteenable[0]) begin
                if (avs_address == `ODBC_REG_CODE) begin
                    code_reg <= avs_writedata[`ODBC_CODE_MSB:`ODBC_CODE_LSB];
                    chan_reg <= avs_writedata[`ODBC_CHAN_MSB:`ODBC_CHAN_LSB];
                end
                if (avs_address == `ODBC_REG_LOAD)
                    load_mask <= avs_writedata[N_PAIR-1:0];
                if (avs_address == `ODBC_REG_CTRL) begin
                    twos_mode <= avs_writedata[`ODBC_CTRL_TWOS];
                    // Clear wins over write, write over load
                    if (avs_writedata[`ODBC_CTRL_CLEAR]) begin
                        state <= S_CLEAR;
                        count <= C_CLR;
                        clear_all_n <= 1'b0;
                        code_reg <= `ODBC_MID_CODE;
                    end else if (avs_writedata[`ODBC_CTRL_WRITE]) begin
                        // Select lines and code settle before strobing
                        state <= S_SETUP;
                        count <= C_SETUP;
                        ld_with_wr <= avs_writedata[`ODBC_CTRL_LDWR];
                        channel_select_bit0 <= chan_reg[0];
                        channel_select_bit1 <= chan_reg[1];
                        channel_select_bit2 <= chan_reg[2];
                        code_bus <= next_code;
                        chip_select_n <= 1'b0;
                    end else if (avs_writedata[`ODBC_CTRL_LOAD]) begin
                        // Every pair in the mask opens at once
                        state <= S_LOAD;
                        count <= C_LD;
                        load_out_n <= ~load_mask;
                    end
                end
            end else begin
                case (state)
                    S_IDLE: begin
                        count <= 4'h0;
                    end
                    // Chip select is low; strobe once setup has elapsed
                    S_SETUP: begin
                        if (count <= 4'h1) begin
                            state <= S_STROBE;
                            count <= C_WR;
                            write_strobe_n <= 1'b0;
                            if (ld_with_wr)
                                load_out_n <= ~pair_of_chan;
                        end else
                            count <= count - 4'h1;
                    end
                    S_STROBE: begin
                        // Select lines stay fixed for the whole strobe
                        if (count <= 4'h1) begin
                            write_strobe_n <= 1'b1;
                            chip_select_n <= 1'b1;
                            if (ld_with_wr) begin
                                state <= S_LDHOLD;
                                count <= C_LD;
                            end else
                                state <= S_IDLE;
                        end else
                            count <= count - 4'h1;
                    end
                    S_LDHOLD, S_LOAD: begin
                        // Load stays low its pulse time after the strobe
                        if (count <= 4'h1) begin
                            load_out_n <= {N_PAIR{1'b1}};
                            state <= S_IDLE;
                        end else
                            count <= count - 4'h1;
                    end
                    S_CLEAR: begin
                        if (count <= 4'h1) begin
                            clear_all_n <= 1'b1;
                            state <= S_IDLE;
                        end else
                            count <= count - 4'h1;
                    end
                    default: state <= S_IDLE;
                endcase
            end
            // Pin drive follows the internal load vector one cycle later
            // Keeping the pins on their own flip-flops gives glitch-free
            // levels on asynchronous inputs of the converter
            load_pair_first_n <= load_out_n[0];
            load_pair_second_n <= load_out_n[1];
            load_pair_third_n <= load_out_n[2];
            load_pair_fourth_n <= load_out_n[3];
        end
    end
endmodule // odbc_host
`default_nettype wire

//--- tb/odbc_host_monitor.sv
/*
 Checker on the host controller's converter pins and bus handshake.
 Assumes one clock, clk, and an asynchronous active-low reset, rst_b.
*/
`timescale 1ns/1ps
`default_nettype none
module odbc_host_chk #(parameter CODE_W = 13) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic avs_waitrequest, // Stall
    input wire logic chip_select_n, // Chip select
    input wire logic write_strobe_n, // Write strobe
    input wire logic channel_select_bit0, // Index bit 0
    input wire logic channel_select_bit1, // Index bit 1
    input wire logic channel_select_bit2, // Index bit 2
    input wire logic [CODE_W-1:0] code_bus, // Code
    input wire logic load_pair_fourth_n, // Last pair load
    input wire logic clear_all_n // Clear
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [2:0] sel = {channel_select_bit2, channel_select_bit1,
        channel_select_bit0};
    // Strobe and clear pulses of one cycle
    sequence strobe_s; !write_strobe_n ##1 (write_strobe_n && chip_select_n);
    endsequence
    sequence clr_s; (!clear_all_n && chip_select_n) ##1 clear_all_n;
    endsequence
    ack_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bad ack");
    wr_setup_a: assert property ($fell(write_strobe_n) |->
        $past(!chip_select_n) and strobe_s) else $error("bad strobe");
    sel_hold_a: assert property (!chip_select_n && !write_strobe_n
        |-> $stable(sel)) else $error("select moved in write");
    code_hold_a: assert property (!write_strobe_n
        |-> $stable(code_bus)) else $error("code moved in write");
    wr_in_cs_a: assert property (!write_strobe_n
        |-> !chip_select_n && clear_all_n) else $error("strobe alone");
    load_hold_a: assert property ($rose(write_strobe_n)
        && !load_pair_fourth_n |=> !load_pair_fourth_n)
        else $error("load released early");
    clr_pulse_a: assert property ($fell(clear_all_n) |-> clr_s)
        else $error("bad clear pulse");
    ld_single_a: assert property ($fell(load_pair_fourth_n)
        && write_strobe_n && $past(write_strobe_n) |=> load_pair_fourth_n)
        else $error("load pulse too long");
endmodule // odbc_host_chk
bind odbc_host odbc_host_chk #(.CODE_W(CODE_W)) odbc_host_chk_inst (
    .clk(clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n),
    .channel_select_bit0(channel_select_bit0),
    .channel_select_bit1(channel_select_bit1),
    .channel_select_bit2(channel_select_bit2), .code_bus(code_bus),
    .load_pair_fourth_n(load_pair_fourth_n), .clear_all_n(clear_all_n));
`default_nettype wire

//--- tb/odbc_dac_model.sv
/*
 Level-sensitive model of the eight-channel double-buffered latches.
 Assumes the pins come straight from the host controller.
*/
`timescale 1ns/1ps
`default_nettype none
module odbc_dac_model (
    input wire logic chip_select_n, // Chip select
    input wire logic write_strobe_n, // Write strobe
    input wire logic [2:0] channel_select, // Channel index
    input wire logic [12:0] code_bus, // Code
    input wire logic [3:0] pair_load_n, // Pair loads
    input wire logic clear_all_n, // Clear
    output logic [12:0] channel_output [0:7] // Converter latches
);
    logic [12:0] in_q [0:7];
    // Power-up at mid-scale
    initial for (int i = 0; i < 8; i++) begin
        in_q[i] = 13'h1000;
        channel_output[i] = 13'h1000;
    end
    // Input latches; clear wins
    always @* begin
        if (!clear_all_n) for (int i = 0; i < 8; i++) in_q[i] = 13'h1000;
        else if (!chip_select_n && !write_strobe_n)
            in_q[channel_select] = code_bus;
    end
    // Converter latches
    always @* begin
        for (int i = 0; i < 8; i++)
            if (!clear_all_n) channel_output[i] = 13'h1000;
            else if (!pair_load_n[i/2]) channel_output[i] = in_q[i];
    end
endmodule // odbc_dac_model
`default_nettype wire

//--- tb/odbc_host_test.sv
/*
 Self-checking bench: Avalon master tasks drive odbc_host, which drives
 the latch model. Assumes a 10 MHz clock and a two-cycle reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odbc_regs.vh"
module odbc_host_test;
    logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, cs_n, wr_n, s0, s1, s2, clr_n;
    logic [12:0] code, exp [0:7], dac [0:7];
    logic [3:0] ld_n;
    int failures = 0, cmp_count = 0, cyc = 0;
    always #50 clk = ~clk;
    odbc_host odbc_host_inst (.clk(clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chip_select_n(cs_n),
        .write_strobe_n(wr_n), .channel_select_bit0(s0),
        .channel_select_bit1(s1), .channel_select_bit2(s2), .code_bus(code),
        .load_pair_first_n(ld_n[0]), .load_pair_second_n(ld_n[1]),
        .load_pair_third_n(ld_n[2]), .load_pair_fourth_n(ld_n[3]),
        .clear_all_n(clr_n));
    odbc_dac_model odbc_dac_model_inst (.chip_select_n(cs_n),
        .write_strobe_n(wr_n), .channel_select({s2, s1, s0}),
        .code_bus(code), .pair_load_n(ld_n), .clear_all_n(clr_n),
        .channel_output(dac));
    task wrap_up;
        if (failures == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a; avs_writedata <= d;
        avs_write <= w; avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0; avs_read <= 1'b0;
    endtask
    task go(input logic [31:0] ctrl);
        av(1'b1, `ODBC_REG_CTRL, ctrl);
        do av(1'b0, `ODBC_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
    endtask
    task put(input int ch, input logic [12:0] c, input logic [31:0] ctrl);
        av(1'b1, `ODBC_REG_CODE, {13'h0, ch[2:0], 3'h0, c});
        go(ctrl);
    endtask
    task see;
        for (int i = 0; i < 8; i++) chk("output", exp[i], dac[i]);
    endtask
    task t_reset;
        for (int i = 0; i < 8; i++) exp[i] = 13'h1000;
        see();
        av(1'b0, `ODBC_REG_LOAD, 32'h0);
        chk("load mask", 32'hf, rd);
    endtask
    task t_all;
        for (int i = 0; i < 8; i++) put(i, 13'h0a50 + 13'(i), 32'h1);
        see();
        av(1'b1, `ODBC_REG_LOAD, 32'hf);
        go(32'h2);
        for (int i = 0; i < 8; i++) exp[i] = 13'h0a50 + 13'(i);
        see();
    endtask
    task t_pair;
        for (int p = 0; p < 4; p++) begin
            av(1'b1, `ODBC_REG_LOAD, 32'h1 << p);
            put(2*p, 13'h1c00 + 13'(p), 32'h1);
            put(2*p+1, 13'h1c10 + 13'(p), 32'h1);
            go(32'h2);
            exp[2*p] = 13'h1c00 + 13'(p);
            exp[2*p+1] = 13'h1c10 + 13'(p);
            see();
        end
    endtask
    task t_direct;
        put(7, 13'h0777, 32'h11);
        exp[7] = 13'h0777;
        see();
        put(3, 13'h1fff, 32'h19);
        exp[3] = 13'h0fff;
        see();
        av(1'b0, `ODBC_REG_CTRL, 32'h0);
        chk("mode", 32'h1, {31'h0, rd[3]});
    endtask
    task t_clear;
        go(32'h4);
        for (int i = 0; i < 8; i++) exp[i] = 13'h1000;
        see();
        av(1'b1, `ODBC_REG_LOAD, 32'hf);
        go(32'h2);
        see();
        av(1'b0, `ODBC_REG_CODE, 32'h0);
        chk("code reg", 32'h1000, {19'h0, rd[12:0]});
        av(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_all();
        t_pair();
        t_direct();
        t_clear();
        wrap_up();
    end
endmodule // odbc_host_test
`default_nettype wire
